// ### hw/btpm_pkg.sv
package btpm_pkg;
  localparam int BTPM_NLINK = 32;
  localparam int BTPM_SELW = 5;
  localparam int BTPM_ADDRW = 12;
  localparam int BTPM_CNTW = 16;
  // register byte offsets
  localparam logic [11:0] BTPM_OFS_TEST_CTRL = 12'h020;
  localparam logic [11:0] BTPM_OFS_EVT_SEL = 12'h024;
  localparam logic [11:0] BTPM_OFS_LOOPBACK = 12'h028;
  localparam logic [11:0] BTPM_OFS_CNT1 = 12'h02c;
  localparam logic [11:0] BTPM_OFS_CNT2 = 12'h030;
  localparam logic [11:0] BTPM_OFS_IRQ_STAT = 12'h034;
  localparam logic [11:0] BTPM_OFS_IRQ_MASK = 12'h038;
  // test port control fields
  localparam int BTPM_RX_SEL_LSB = 0;
  localparam int BTPM_RX_EN_BIT = 7;
  localparam int BTPM_TX_SEL_LSB = 8;
  localparam int BTPM_TX_EN_BIT = 15;
  localparam logic [31:0] BTPM_TEST_CTRL_MASK = 32'h0000_9f9f;
  // event select fields
  localparam int BTPM_NEVT = 7;
  localparam int BTPM_CNT1_LSB = 0;
  localparam int BTPM_CNT2_LSB = 8;
  localparam logic [31:0] BTPM_EVT_SEL_MASK = 32'h0000_7f7f;
  // event bit order within each seven-bit group
  localparam int BTPM_EV_SMALL = 0;
  localparam int BTPM_EV_FCS = 1;
  localparam int BTPM_EV_RXABRT = 2;
  localparam int BTPM_EV_LEN = 3;
  localparam int BTPM_EV_RXGOOD = 4;
  localparam int BTPM_EV_TXABRT = 5;
  localparam int BTPM_EV_TXGOOD = 6;
  // packet length limits in bits
  localparam int BTPM_MIN_BITS_16 = 32;
  localparam int BTPM_MIN_BITS_32 = 48;
  localparam int BTPM_ABORT_ONES = 7;
  localparam int BTPM_LENW = 16;
  // interrupt status bits
  localparam int BTPM_IRQ_CNT1_WRAP = 0;
  localparam int BTPM_IRQ_CNT2_WRAP = 1;
  localparam int BTPM_NIRQ = 2;
  // reset values
  localparam logic [31:0] BTPM_RST_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {
    BTPM_CRC_NONE = 2'h0,
    BTPM_CRC_UNSPEC = 2'h1,
    BTPM_CRC_16 = 2'h2,
    BTPM_CRC_32 = 2'h3
  } btpm_crc_t;
endpackage

// ### hw/btpm_sync.sv
`timescale 1ns/10ps
module btpm_sync
  import btpm_pkg::*;
#(
  parameter int W = 1
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_ff <= '0;
      q_ff <= '0;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

// ### hw/btpm_evcnt.sv
`timescale 1ns/10ps
module btpm_evcnt
  import btpm_pkg::*;
#(
  parameter int CW = BTPM_CNTW
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [BTPM_NEVT-1:0] event_enable,
  input wire logic [BTPM_NEVT-1:0] event_pulse,
  input wire logic clear,
  output logic [CW-1:0] count,
  output logic wrap
);
  logic [CW-1:0] cnt_ff;
  logic wrap_ff;
  wire hit = |(event_enable & event_pulse);
  wire [CW-1:0] nxt_cnt = cnt_ff + CW'(1);

  // one step per cycle even when several enabled events coincide
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cnt_ff <= '0;
      wrap_ff <= 1'b0;
    end
    else
    begin
      wrap_ff <= hit && (&cnt_ff);
      if (hit)
        cnt_ff <= nxt_cnt;
      else if (clear)
        cnt_ff <= '0;
    end
  end

  assign count = cnt_ff;
  assign wrap = wrap_ff;
endmodule

// ### hw/btpm_top.sv
// Summary of operation
// - each register is written as a whole word; an access with all byte enables low does nothing.
// - with receive test enabled, test data and clock follow the receive link picked by the select field.
// - with receive test disabled, the receive test outputs float and the select field is ignored.
// - with transmit test enabled and no loopback on the chosen link, its transmit data is the test input.
// - with transmit test enabled, the transmit test clock is a copy of the chosen link's transmit clock.
// - with transmit test disabled, links not in loopback run normally, the test clock floats, the select is ignored.
// - a link in line loopback sends its receive data, updated on the falling receive clock, over test data.
// - two counters each have seven event enables, bits 0 to 6 and 8 to 14; enabled events count.
// - a small packet is under 32 bits with no, unspecified or 16-bit check, or under 48 with 32-bit check.
// - a received packet whose check sequence disagrees with the computed residue is counted.
// - a receive abort, seven or more ones in a row, is counted.
// - a packet over the maximum length or not a whole number of octets is counted.
// - a packet received without error is counted.
// - each abort inserted in an outgoing stream is counted.
// - each packet transmitted without error is counted.
`timescale 1ns/10ps
module btpm_top
  import btpm_pkg::*;
#(
  parameter int NLINK = BTPM_NLINK,
  parameter int CW = BTPM_CNTW
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [BTPM_ADDRW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0] reg_byte_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic [NLINK-1:0] link_rx_data,
  input wire logic [NLINK-1:0] link_rx_clock,
  input wire logic [NLINK-1:0] link_tx_clock,
  input wire logic [NLINK-1:0] link_tx_data_normal,
  output logic [NLINK-1:0] link_tx_data,
  output logic rx_test_data_out,
  output logic rx_test_data_out_oe,
  output logic rx_test_clock_out,
  output logic rx_test_clock_out_oe,
  input wire logic tx_test_data_in,
  output logic tx_test_clock_out,
  output logic tx_test_clock_out_oe,
  input wire logic rx_pkt_end,
  input wire logic [BTPM_LENW-1:0] rx_pkt_bits,
  input wire logic [1:0] rx_crc_mode,
  input wire logic rx_fcs_mismatch,
  input wire logic [BTPM_LENW-1:0] rx_max_bits,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic tx_abort_inserted,
  input wire logic tx_pkt_good
);

  ////////////////////////////////////////////////////////////////
  // register port

  logic [31:0] test_ctrl_ff;
  logic [31:0] evt_sel_ff;
  logic [NLINK-1:0] loopback_ff;
  logic [BTPM_NIRQ-1:0] irq_stat_ff;
  logic [BTPM_NIRQ-1:0] irq_mask_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;

  wire any_lane = |reg_byte_en;
  wire wr_ok = reg_wr && any_lane;
  wire rd_ok = reg_rd && any_lane;
  wire sel_test = reg_addr == BTPM_OFS_TEST_CTRL;
  wire sel_evt = reg_addr == BTPM_OFS_EVT_SEL;
  wire sel_lb = reg_addr == BTPM_OFS_LOOPBACK;
  wire sel_cnt1 = reg_addr == BTPM_OFS_CNT1;
  wire sel_cnt2 = reg_addr == BTPM_OFS_CNT2;
  wire sel_stat = reg_addr == BTPM_OFS_IRQ_STAT;
  wire sel_mask = reg_addr == BTPM_OFS_IRQ_MASK;

  logic [CW-1:0] cnt1;
  logic [CW-1:0] cnt2;
  logic wrap1;
  logic wrap2;
  wire [BTPM_NIRQ-1:0] irq_evt = {wrap2, wrap1};

  // unmapped addresses read as zero
  wire [31:0] nxt_rdata =
    sel_test ? test_ctrl_ff :
    sel_evt ? evt_sel_ff :
    sel_lb ? 32'(loopback_ff) :
    sel_cnt1 ? 32'(cnt1) :
    sel_cnt2 ? 32'(cnt2) :
    sel_stat ? 32'(irq_stat_ff) :
    sel_mask ? 32'(irq_mask_ff) : 32'h0000_0000;

  // whole-word write, byte lanes otherwise ignored
  always_ff @(posedge clk)
  begin
    if (!rstn)
      test_ctrl_ff <= BTPM_RST_WORD;
    else if (wr_ok && sel_test)
      test_ctrl_ff <= reg_wdata & BTPM_TEST_CTRL_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      evt_sel_ff <= BTPM_RST_WORD;
    else if (wr_ok && sel_evt)
      evt_sel_ff <= reg_wdata & BTPM_EVT_SEL_MASK;
  end

  // one bit per link; loopback on a link outranks the test overwrite
  always_ff @(posedge clk)
  begin
    if (!rstn)
      loopback_ff <= '0;
    else if (wr_ok && sel_lb)
      loopback_ff <= reg_wdata[NLINK-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      irq_mask_ff <= '0;
    else if (wr_ok && sel_mask)
      irq_mask_ff <= reg_wdata[BTPM_NIRQ-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      rdata_ff <= '0;
    else
      rdata_ff <= rd_ok ? nxt_rdata : 32'h0000_0000;
  end

  // read clears status; a new event in the same cycle survives
  wire [BTPM_NIRQ-1:0] nxt_irq_stat = ((rd_ok && sel_stat) ? '0 : irq_stat_ff) | irq_evt;
  // level output lags the status by one cycle so it comes straight from a flop
  wire nxt_irq = |(irq_stat_ff & irq_mask_ff);

  always_ff @(posedge clk)
  begin
    if (!rstn)
      irq_stat_ff <= '0;
    else
      irq_stat_ff <= nxt_irq_stat;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      irq_ff <= 1'b0;
    else
      irq_ff <= nxt_irq;
  end

  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////
  // test port routing

  wire rx_en = test_ctrl_ff[BTPM_RX_EN_BIT];
  wire tx_en = test_ctrl_ff[BTPM_TX_EN_BIT];
  wire [BTPM_SELW-1:0] rx_sel = test_ctrl_ff[BTPM_RX_SEL_LSB +: BTPM_SELW];
  wire [BTPM_SELW-1:0] tx_sel = test_ctrl_ff[BTPM_TX_SEL_LSB +: BTPM_SELW];

  logic [NLINK-1:0] rxd_s;
  logic [NLINK-1:0] rxc_s;
  logic [NLINK-1:0] txc_s;
  logic [NLINK-1:0] txn_s;
  logic tbd_s;

  btpm_sync #(.W(NLINK)) u_sync_rxd (.clk(clk), .rstn(rstn), .d(link_rx_data), .q(rxd_s));
  btpm_sync #(.W(NLINK)) u_sync_rxc (.clk(clk), .rstn(rstn), .d(link_rx_clock), .q(rxc_s));
  btpm_sync #(.W(NLINK)) u_sync_txc (.clk(clk), .rstn(rstn), .d(link_tx_clock), .q(txc_s));
  btpm_sync #(.W(NLINK)) u_sync_txn (.clk(clk), .rstn(rstn), .d(link_tx_data_normal), .q(txn_s));
  btpm_sync #(.W(1)) u_sync_tbd (.clk(clk), .rstn(rstn), .d(tx_test_data_in), .q(tbd_s));

  logic [NLINK-1:0] rxc_d_ff;
  logic [NLINK-1:0] lb_data_ff;
  logic [NLINK-1:0] txd_ff;
  logic rbd_ff;
  logic rx_test_clock_out_ff;
  logic rb_oe_ff;
  logic tx_test_clock_out_ff;
  logic tb_oe_ff;

  wire [NLINK-1:0] rx_fall = rxc_d_ff & ~rxc_s;
  // loopback data taken on the falling receive clock
  wire [NLINK-1:0] nxt_lb_data = (rx_fall & rxd_s) | (~rx_fall & lb_data_ff);
  wire [NLINK-1:0] tx_pick = tx_en ? (NLINK'(1) << tx_sel) : '0;
  wire [NLINK-1:0] ovw = tx_pick & ~loopback_ff;
  wire [NLINK-1:0] keep_normal = ~loopback_ff & ~ovw;
  wire [NLINK-1:0] nxt_txd =
    (loopback_ff & nxt_lb_data) |
    (ovw & {NLINK{tbd_s}}) |
    (keep_normal & txn_s);
  // the select fields only matter while their enables are set
  wire nxt_rbd = rx_en ? rxd_s[rx_sel] : 1'b0;
  wire nxt_rx_test_clock_out = rx_en ? rxc_s[rx_sel] : 1'b0;
  wire nxt_tx_test_clock_out = tx_en ? txc_s[tx_sel] : 1'b0;

  // outputs are resampled, so they lag the pins by three cycles
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rxc_d_ff <= '0;
      lb_data_ff <= '0;
    end
    else
    begin
      rxc_d_ff <= rxc_s;
      lb_data_ff <= nxt_lb_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      txd_ff <= '0;
    else
      txd_ff <= nxt_txd;
  end

  // enable and data share one stage so the pin never drives stale data
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rbd_ff <= 1'b0;
      rx_test_clock_out_ff <= 1'b0;
      rb_oe_ff <= 1'b0;
    end
    else
    begin
      rbd_ff <= nxt_rbd;
      rx_test_clock_out_ff <= nxt_rx_test_clock_out;
      rb_oe_ff <= rx_en;
    end
  end

  // a resampled copy, so the test clock carries up to one cycle of jitter
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tx_test_clock_out_ff <= 1'b0;
      tb_oe_ff <= 1'b0;
    end
    else
    begin
      tx_test_clock_out_ff <= nxt_tx_test_clock_out;
      tb_oe_ff <= tx_en;
    end
  end

  assign link_tx_data = txd_ff;
  assign rx_test_data_out = rbd_ff;
  assign rx_test_data_out_oe = rb_oe_ff;
  assign rx_test_clock_out = rx_test_clock_out_ff;
  assign rx_test_clock_out_oe = rb_oe_ff;
  assign tx_test_clock_out = tx_test_clock_out_ff;
  assign tx_test_clock_out_oe = tb_oe_ff;

  ////////////////////////////////////////////////////////////////
  // event detection

  logic [3:0] ones_ff;
  logic abort_seen_ff;

  function automatic logic is_small(input logic [BTPM_LENW-1:0] bits, input logic [1:0] mode);
    if (mode == BTPM_CRC_32)
      is_small = bits < BTPM_LENW'(BTPM_MIN_BITS_32);
    else
      is_small = bits < BTPM_LENW'(BTPM_MIN_BITS_16);
  endfunction

  wire ev_small = rx_pkt_end && is_small(rx_pkt_bits, rx_crc_mode);
  wire ev_fcs = rx_pkt_end && rx_fcs_mismatch;
  wire len_over = rx_pkt_bits > rx_max_bits;
  wire len_odd = rx_pkt_bits[2:0] != 3'h0;
  wire ev_len = rx_pkt_end && (len_over || len_odd);
  wire ev_good = rx_pkt_end && !ev_small && !ev_fcs && !ev_len;
  wire [3:0] nxt_ones = (ones_ff == 4'(BTPM_ABORT_ONES)) ? ones_ff : ones_ff + 4'h1;
  // one count per run of seven or more ones, however long
  wire ev_abort = rx_bit_valid && rx_bit && (nxt_ones == 4'(BTPM_ABORT_ONES)) && !abort_seen_ff;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ones_ff <= '0;
      abort_seen_ff <= 1'b0;
    end
    else if (rx_bit_valid)
    begin
      ones_ff <= rx_bit ? nxt_ones : 4'h0;
      abort_seen_ff <= rx_bit && (abort_seen_ff || ev_abort);
    end
  end

  logic [BTPM_NEVT-1:0] ev_vec;
  always_comb
  begin
    ev_vec = '0;
    ev_vec[BTPM_EV_SMALL] = ev_small;
    ev_vec[BTPM_EV_FCS] = ev_fcs;
    ev_vec[BTPM_EV_RXABRT] = ev_abort;
    ev_vec[BTPM_EV_LEN] = ev_len;
    ev_vec[BTPM_EV_RXGOOD] = ev_good;
    ev_vec[BTPM_EV_TXABRT] = tx_abort_inserted;
    ev_vec[BTPM_EV_TXGOOD] = tx_pkt_good;
  end

  // a write to a counter clears it unless an enabled event hits in that cycle; the data word is not used
  wire clr1 = wr_ok && sel_cnt1;
  wire clr2 = wr_ok && sel_cnt2;

  // both counters see the same event vector independently
  btpm_evcnt #(.CW(CW)) u_cnt1 (
    .clk(clk),
    .rstn(rstn),
    .event_enable(evt_sel_ff[BTPM_CNT1_LSB +: BTPM_NEVT]),
    .event_pulse(ev_vec),
    .clear(clr1),
    .count(cnt1),
    .wrap(wrap1)
  );

  btpm_evcnt #(.CW(CW)) u_cnt2 (
    .clk(clk),
    .rstn(rstn),
    .event_enable(evt_sel_ff[BTPM_CNT2_LSB +: BTPM_NEVT]),
    .event_pulse(ev_vec),
    .clear(clr2),
    .count(cnt2),
    .wrap(wrap2)
  );

endmodule

// ### tb/btpm_top_properties.sv
`timescale 1ns/10ps
module btpm_top_properties
  import btpm_pkg::*;
#(
  parameter int NLINK = BTPM_NLINK
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [BTPM_ADDRW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0] reg_byte_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [NLINK-1:0] link_rx_data,
  input wire logic [NLINK-1:0] link_rx_clock,
  input wire logic [NLINK-1:0] link_tx_clock,
  input wire logic [NLINK-1:0] link_tx_data_normal,
  input wire logic [NLINK-1:0] link_tx_data,
  input wire logic rx_test_data_out,
  input wire logic rx_test_data_out_oe,
  input wire logic rx_test_clock_out,
  input wire logic tx_test_data_in,
  input wire logic tx_test_clock_out,
  input wire logic tx_test_clock_out_oe
);
  logic [31:0] ctl_ff;
  logic [NLINK-1:0] lb_ff;
  logic [2:0] age_ff;
  wire acc = reg_wr && (reg_byte_en != 4'h0);
  wire wc = acc && (reg_addr == BTPM_OFS_TEST_CTRL);
  wire wl = acc && (reg_addr == BTPM_OFS_LOOPBACK);
  wire [4:0] rs = ctl_ff[4:0];
  wire [4:0] ts = ctl_ff[12:8];
  // outputs lag a write by one cycle; judge only once seven cycles have passed since it
  wire ok = (age_ff == 3'h7);
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctl_ff <= 32'h0;
      lb_ff <= '0;
      age_ff <= 3'h0;
    end
    else
    begin
      if (wc) ctl_ff <= reg_wdata & BTPM_TEST_CTRL_MASK;
      if (wl) lb_ff <= reg_wdata[NLINK-1:0];
      if (wc || wl) age_ff <= 3'h0;
      else if (!ok) age_ff <= age_ff + 3'h1;
    end
  end
  a_rx_float: assert property (@(posedge clk) disable iff (!rstn)
    ok && !ctl_ff[7] |-> !rx_test_data_out_oe) else $error("rx test port driven while off");
  a_rx_follow: assert property (@(posedge clk) disable iff (!rstn)
    ok && ctl_ff[7] |-> rx_test_data_out_oe && rx_test_data_out == $past(link_rx_data[rs], 3)
    && rx_test_clock_out == $past(link_rx_clock[rs], 3)) else $error("rx test port wrong link");
  a_tx_clock: assert property (@(posedge clk) disable iff (!rstn)
    ok && ctl_ff[15] |-> tx_test_clock_out_oe && tx_test_clock_out == $past(link_tx_clock[ts], 3))
    else $error("tx test clock wrong link");
  a_tx_float: assert property (@(posedge clk) disable iff (!rstn)
    ok && !ctl_ff[15] |-> !tx_test_clock_out_oe) else $error("tx test clock driven while off");
  a_tx_normal: assert property (@(posedge clk) disable iff (!rstn)
    ok && !ctl_ff[15] && lb_ff == '0 |-> link_tx_data == $past(link_tx_data_normal, 3))
    else $error("tx links not normal");
  a_tx_over: assert property (@(posedge clk) disable iff (!rstn)
    ok && ctl_ff[15] && !lb_ff[ts] |-> link_tx_data[ts] == $past(tx_test_data_in, 3))
    else $error("tx link not overwritten");
  a_ctl_read: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && reg_byte_en != 4'h0 && reg_addr == BTPM_OFS_TEST_CTRL |=> reg_rdata == ctl_ff)
    else $error("test control readback wrong");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
    !(reg_rd && reg_byte_en != 4'h0) |=> reg_rdata == 32'h0) else $error("read data without access");
endmodule

// ### tb/btpm_bert_eq.sv
`timescale 1ns/10ps
module btpm_bert_eq (
  input wire logic tx_test_clock_out,
  input wire logic tx_test_clock_out_oe,
  output logic tx_test_data_in
);
  logic [3:0] lfsr_ff = 4'h1;
  assign tx_test_data_in = lfsr_ff[0];
  // launch on the falling test clock so the device sees a stable bit
  always @(negedge tx_test_clock_out or negedge tx_test_clock_out_oe)
    lfsr_ff <= {lfsr_ff[2:0], lfsr_ff[3] ^ lfsr_ff[2]};
endmodule

// ### tb/btpm_top_tb.sv
`timescale 1ns/10ps
module btpm_top_tb
  import btpm_pkg::*;
;
  logic clk = 1'h0, rstn = 1'h0, lclk, reg_wr = 1'h0, reg_rd = 1'h0, rx_pkt_end = 1'h0, rx_fcs_mismatch = 1'h0;
  logic rx_bit_valid = 1'h0, rx_bit = 1'h0, tx_abort_inserted = 1'h0, tx_pkt_good = 1'h0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0, link_rx_data = 32'h0, link_rx_clock = 32'h0, link_tx_data_normal = 32'ha5a5_a5a5;
  logic [3:0] reg_byte_en = 4'h0;
  logic [15:0] rx_pkt_bits = 16'h0, rx_max_bits = 16'h0100;
  logic [1:0] rx_crc_mode = 2'h0;
  logic [31:0] reg_rdata, link_tx_data;
  logic irq, rx_test_data_out, rx_test_data_out_oe, rx_test_clock_out, rx_test_clock_out_oe;
  logic tx_test_data_in, tx_test_clock_out, tx_test_clock_out_oe;
  int bad_count = 0, checked = 0;
  always #12.5 clk = ~clk;
  initial
  begin
    lclk = 1'h0;
    #3;
    forever #100 lclk = ~lclk;
  end
  btpm_top i_btpm_top (
    .clk(clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_byte_en(reg_byte_en),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .irq(irq),
    .link_rx_data(link_rx_data),
    .link_rx_clock(link_rx_clock),
    .link_tx_clock({32{lclk}}),
    .link_tx_data_normal(link_tx_data_normal),
    .link_tx_data(link_tx_data),
    .rx_test_data_out(rx_test_data_out),
    .rx_test_data_out_oe(rx_test_data_out_oe),
    .rx_test_clock_out(rx_test_clock_out),
    .rx_test_clock_out_oe(rx_test_clock_out_oe),
    .tx_test_data_in(tx_test_data_in),
    .tx_test_clock_out(tx_test_clock_out),
    .tx_test_clock_out_oe(tx_test_clock_out_oe),
    .rx_pkt_end(rx_pkt_end),
    .rx_pkt_bits(rx_pkt_bits),
    .rx_crc_mode(rx_crc_mode),
    .rx_fcs_mismatch(rx_fcs_mismatch),
    .rx_max_bits(rx_max_bits),
    .rx_bit_valid(rx_bit_valid),
    .rx_bit(rx_bit),
    .tx_abort_inserted(tx_abort_inserted),
    .tx_pkt_good(tx_pkt_good)
  );
  btpm_bert_eq i_btpm_bert_eq (
    .tx_test_clock_out(tx_test_clock_out),
    .tx_test_clock_out_oe(tx_test_clock_out_oe),
    .tx_test_data_in(tx_test_data_in)
  );
  ////////////////////////////////////////
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] be);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_byte_en <= be;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e, string n);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    reg_byte_en <= 4'hf;
    @(posedge clk);
    reg_rd <= 1'h0;
    // read data stands only until the next rising edge
    @(negedge clk);
    chk(n, e, reg_rdata);
  endtask
  task automatic w8();
    repeat (8) @(posedge clk);
  endtask
  task automatic t_regs();
    rd(BTPM_OFS_TEST_CTRL, 32'h0, "ctl reset");
    rd(BTPM_OFS_EVT_SEL, 32'h0, "evt reset");
    wr(BTPM_OFS_TEST_CTRL, 32'hffff_ffff, 4'h0);
    rd(BTPM_OFS_TEST_CTRL, 32'h0, "ctl no lanes");
    wr(BTPM_OFS_TEST_CTRL, 32'hffff_ffff, 4'h8);
    rd(BTPM_OFS_TEST_CTRL, 32'h9f9f, "ctl word");
    wr(BTPM_OFS_EVT_SEL, 32'hffff_ffff, 4'h2);
    rd(BTPM_OFS_EVT_SEL, 32'h7f7f, "evt word");
    rd(12'h0fc, 32'h0, "unmapped");
  endtask
  task automatic t_rx();
    wr(BTPM_OFS_TEST_CTRL, 32'h9f, 4'hf);
    link_rx_data <= 32'h8000_0000;
    link_rx_clock <= 32'h7fff_ffff;
    w8();
    chk("rx port", 32'h6, {rx_test_data_out_oe, rx_test_data_out, rx_test_clock_out});
    link_rx_data <= 32'h7fff_ffff;
    link_rx_clock <= 32'h8000_0000;
    w8();
    chk("rx port", 32'h5, {rx_test_data_out_oe, rx_test_data_out, rx_test_clock_out});
    wr(BTPM_OFS_TEST_CTRL, 32'h1f, 4'hf);
    w8();
    chk("rx oe", 32'h0, {rx_test_data_out_oe, rx_test_clock_out_oe});
  endtask
  task automatic t_tx();
    wr(BTPM_OFS_TEST_CTRL, 32'h8500, 4'hf);
    repeat (4)
    begin
      @(negedge tx_test_clock_out);
      repeat (5) @(posedge clk);
      chk("tx lanes", {tx_test_data_in, 2'h1}, {link_tx_data[5], link_tx_data[6], tx_test_clock_out_oe});
    end
    wr(BTPM_OFS_LOOPBACK, 32'h20, 4'hf);
    link_rx_clock <= 32'hffff_ffff;
    link_rx_data <= 32'h20;
    w8();
    link_rx_clock <= 32'h0;
    w8();
    chk("loopback", 32'h1, link_tx_data[5]);
    link_rx_data <= 32'h0;
    w8();
    chk("loopback hold", 32'h1, link_tx_data[5]);
    link_rx_clock <= 32'hffff_ffff;
    w8();
    link_rx_clock <= 32'h0;
    w8();
    chk("loopback", 32'h0, link_tx_data[5]);
    wr(BTPM_OFS_LOOPBACK, 32'h0, 4'hf);
    wr(BTPM_OFS_TEST_CTRL, 32'h0500, 4'hf);
    w8();
    chk("tx oe", 32'h0, tx_test_clock_out_oe);
  endtask
  task automatic ev(int e);
    int i;
    @(posedge clk);
    if (e == 2)
    begin
      for (i = 0; i < 9; i++)
      begin
        rx_bit_valid <= 1'h1;
        rx_bit <= (i < 7);
        @(posedge clk);
      end
      rx_bit_valid <= 1'h0;
    end
    else
    begin
      rx_pkt_end <= (e < 5);
      rx_pkt_bits <= (e == 0) ? 16'h0028 : (e == 3) ? 16'h0044 : 16'h0040;
      rx_crc_mode <= (e == 0) ? BTPM_CRC_32 : BTPM_CRC_16;
      rx_fcs_mismatch <= (e == 1);
      tx_abort_inserted <= (e == 5);
      tx_pkt_good <= (e == 6);
      @(posedge clk);
      rx_pkt_end <= 1'h0;
      tx_abort_inserted <= 1'h0;
      tx_pkt_good <= 1'h0;
    end
  endtask
  task automatic t_events();
    int e, p;
    logic [31:0] s;
    for (e = 0; e < 7; e++)
      for (p = 0; p < 2; p++)
      begin
        s = 32'h1 << e;
        s = s | ((p != 0 ? s : (~s & 32'h7f)) << 8);
        wr(BTPM_OFS_EVT_SEL, s, 4'h1);
        wr(BTPM_OFS_CNT1, 32'h0, 4'hf);
        wr(BTPM_OFS_CNT2, 32'h0, 4'hf);
        ev(e);
        rd(BTPM_OFS_CNT1, 32'h1, "cnt1");
        rd(BTPM_OFS_CNT2, p, "cnt2");
      end
  endtask
  task automatic t_irq();
    wr(BTPM_OFS_EVT_SEL, 32'h40, 4'hf);
    wr(BTPM_OFS_CNT1, 32'h0, 4'hf);
    wr(BTPM_OFS_IRQ_MASK, 32'h3, 4'hf);
    tx_pkt_good <= 1'h1;
    repeat (65540) @(posedge clk);
    tx_pkt_good <= 1'h0;
    w8();
    chk("irq", 32'h1, irq);
    wr(BTPM_OFS_IRQ_MASK, 32'h0, 4'hf);
    w8();
    chk("irq masked", 32'h0, irq);
    wr(BTPM_OFS_IRQ_MASK, 32'h1, 4'hf);
    w8();
    chk("irq", 32'h1, irq);
    rd(BTPM_OFS_IRQ_STAT, 32'h1, "status");
    rd(BTPM_OFS_IRQ_STAT, 32'h0, "status cleared");
    chk("irq cleared", 32'h0, irq);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #2_500_000;
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    repeat (3) @(posedge clk);
    t_regs();
    t_rx();
    t_tx();
    t_events();
    t_irq();
    report_and_stop();
  end
endmodule
bind btpm_top btpm_top_properties #(.NLINK(NLINK)) i_btpm_top_properties (
  .clk(clk),
  .rstn(rstn),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_byte_en(reg_byte_en),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .link_rx_data(link_rx_data),
  .link_rx_clock(link_rx_clock),
  .link_tx_clock(link_tx_clock),
  .link_tx_data_normal(link_tx_data_normal),
  .link_tx_data(link_tx_data),
  .rx_test_data_out(rx_test_data_out),
  .rx_test_data_out_oe(rx_test_data_out_oe),
  .rx_test_clock_out(rx_test_clock_out),
  .tx_test_data_in(tx_test_data_in),
  .tx_test_clock_out(tx_test_clock_out),
  .tx_test_clock_out_oe(tx_test_clock_out_oe)
);
